// File: hw/fslr_consts.svh
// Constants of the four-stage shift/load register block: register offsets,
// field positions, reset values and storage sizes.
// Included by the package users; holds definitions only.
`ifndef FSLR_CONSTS_SVH
`define FSLR_CONSTS_SVH

// Register byte offsets, decoded on haddr[7:0]
`define FSLR_OFF_CMD        8'h00
`define FSLR_OFF_STEP       8'h04
`define FSLR_OFF_CTRL       8'h08
`define FSLR_OFF_STATUS     8'h0C
`define FSLR_OFF_MISSED     8'h10

// Command word fields
`define FSLR_CMD_RUN_BIT    0
`define FSLR_CMD_LSEL_BIT   1
`define FSLR_CMD_SER_BIT    2
`define FSLR_CMD_WORD_LSB   4
`define FSLR_CMD_WORD_MSB   7

// Control fields
`define FSLR_CTRL_PIN_BIT   0
`define FSLR_CTRL_RST       1'b1

// Status fields
`define FSLR_ST_STG_LSB     0
`define FSLR_ST_STG_MSB     3
`define FSLR_ST_INV_BIT     4
`define FSLR_ST_HEAD_BIT    8
`define FSLR_ST_FULL_BIT    9
`define FSLR_ST_LVL_LSB     12
`define FSLR_ST_LVL_MSB     15

// Reset values and the MISSED saturation limit
`define FSLR_STAGES_RST     4'h0
`define FSLR_INV_RST        1'b1
`define FSLR_MISSED_RST     8'h00
`define FSLR_MISSED_MAX     8'hFF

// Storage
`define FSLR_ENTRY_W        7
`define FSLR_FIFO_DEPTH     8
`define FSLR_LVL_W          4

`endif

// File: hw/fslr_pkg.sv
// Types shared by the shift/load register block and its command queue.
// Assumes the constants header is on the include path.
`include "fslr_consts.svh"

package fslr_pkg;

   // One queued step: data and controls sampled at one register clock edge
   typedef struct packed {
      logic [3:0] load_word;
      logic       serial_in;
      logic       load_select_low;
      logic       run_low;
   } fslr_entry_t;

   // Bus slave data-phase states
   typedef enum logic [1:0] {
      FSLR_BUS_IDLE  = 2'b00,
      FSLR_BUS_WDATA = 2'b01
   } fslr_bus_t;

endpackage

// File: hw/fslr_fifo_if.sv
// Valid/ready link between the register block and its command queue.
// Both ends run on the same clock.
`timescale 1ns/10ps
`include "fslr_consts.svh"

interface fslr_fifo_if #(
   parameter int WIDTH = `FSLR_ENTRY_W
);
   logic             in_valid;
   logic             in_ready;
   logic [WIDTH-1:0] in_data;
   logic             out_valid;
   logic             out_ready;
   logic [WIDTH-1:0] out_data;

   modport fill (
      output in_valid,
      output in_data,
      input  in_ready,
      input  out_valid,
      input  out_data,
      output out_ready
   );

   modport store (
      input  in_valid,
      input  in_data,
      output in_ready,
      output out_valid,
      output out_data,
      input  out_ready
   );
endinterface

// File: hw/fslr_fifo.sv
// Command queue: DEPTH words in a small memory plus a registered head word.
// Assumes one clock, synchronous push/pop, and that ce freezes both ends.
`timescale 1ns/10ps
`include "fslr_consts.svh"

module fslr_fifo #(
   parameter int WIDTH = `FSLR_ENTRY_W,
   parameter int DEPTH = `FSLR_FIFO_DEPTH
) (
   // Clock, enable, reset
   input  wire logic                         mclk,
   input  wire logic                         ce,
   input  wire logic                         rst,
   // Queue ports
   fslr_fifo_if.store                        q,
   output logic [$clog2(DEPTH+1)-1:0]        level
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    wr_d;
   logic [AW-1:0]    rd_q;
   logic [AW-1:0]    rd_d;
   logic [CW-1:0]    cnt_q;
   logic [CW-1:0]    cnt_d;
   logic [WIDTH-1:0] head_q;
   logic [WIDTH-1:0] head_d;
   logic             hv_q;
   logic             hv_d;
   logic             push;
   logic             take;
   logic             load;

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction

   always_comb begin
      push   = q.in_valid && (cnt_q != CW'(DEPTH));
      take   = hv_q && q.out_ready;
      // Head refills as soon as it is empty or being taken
      load   = (!hv_q || take) && (cnt_q != '0);
      wr_d   = push ? ptr_inc(wr_q) : wr_q;
      rd_d   = load ? ptr_inc(rd_q) : rd_q;
      cnt_d  = cnt_q;
      if (push) begin
         cnt_d = cnt_d + CW'(1);
      end
      if (load) begin
         cnt_d = cnt_d - CW'(1);
      end
      head_d = load ? mem[rd_q] : head_q;
      hv_d   = load || (hv_q && !take);
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wr_q   <= '0;
         rd_q   <= '0;
         cnt_q  <= '0;
         head_q <= '0;
         hv_q   <= 1'b0;
      end else if (ce) begin
         wr_q   <= wr_d;
         rd_q   <= rd_d;
         cnt_q  <= cnt_d;
         head_q <= head_d;
         hv_q   <= hv_d;
      end
   end

   // Storage array needs no reset; reads are guarded by the count
   always_ff @(posedge mclk) begin
      if (ce && push) begin
         mem[wr_q] <= q.in_data;
      end
   end

   assign q.in_ready  = (cnt_q != CW'(DEPTH));
   assign q.out_valid = hv_q;
   assign q.out_data  = head_q;
   assign level       = cnt_q;

endmodule

// File: hw/fslr_top.sv
// Four-stage shift/load register with an AHB-Lite command and status port.
// Assumes all inputs except clear_low and rst are synchronous to mclk,
// a single AHB-Lite master, and that hready is this slave's hreadyout.
// Registers: CMD queues one step, STEP makes one software clock edge,
// CTRL gates the clock pin, STATUS mirrors stages and queue, MISSED
// counts clock edges that found the queue empty.
// Steps wait in a nine-deep queue; pin edges and STEP writes release them.
//
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
`include "fslr_consts.svh"

module fslr_top (
   // Clock, enable, reset
   input  wire logic        mclk,
   input  wire logic        ce,
   input  wire logic        rst,
   // Register pins
   input  wire logic        clk_input,
   input  wire logic        clear_low,
   output logic [3:0]       reg_outputs,
   output logic             last_stage_inverse,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata
);
   import fslr_pkg::*;

   fslr_fifo_if #(.WIDTH(`FSLR_ENTRY_W)) cmdq ();

   // Queue level counts the memory words only, not the head
   logic [`FSLR_LVL_W-1:0] fifo_level;

   // Bus state
   fslr_bus_t   bus_q;
   fslr_bus_t   bus_d;
   logic [7:0]  dp_addr_q;
   logic [7:0]  dp_addr_d;
   logic        hready_q;
   logic        hready_d;
   logic [31:0] hrdata_q;
   logic [31:0] hrdata_d;
   logic        hresp_q;
   logic        pin_en_q;
   logic        pin_en_d;
   logic        step_q;
   logic        step_d;
   logic        missed_clr;
   logic        accept;

   // Register engine state
   logic [3:0]  stages_q;
   logic [3:0]  stages_d;
   logic        inv_q;
   logic        inv_d;
   logic        clk_in_q;
   logic        clk_in_d;
   logic [7:0]  missed_q;
   logic [7:0]  missed_d;
   logic        reg_edge;
   fslr_entry_t head;

   // Register select on the low address byte; upper bits alias
   function automatic logic is_reg(input logic [7:0] a,
                                   input logic [7:0] off);
      return a == off;
   endfunction

   // Bit 3 of the command word is spare and ignored
   function automatic fslr_entry_t cmd_to_entry(input logic [31:0] w);
      fslr_entry_t e;
      e.load_word       = w[`FSLR_CMD_WORD_MSB:`FSLR_CMD_WORD_LSB];
      e.serial_in       = w[`FSLR_CMD_SER_BIT];
      e.load_select_low = w[`FSLR_CMD_LSEL_BIT];
      e.run_low         = w[`FSLR_CMD_RUN_BIT];
      return e;
   endfunction

   // Next stage contents for one register clock edge
   function automatic logic [3:0] stage_next(input logic [3:0]  s,
                                             input fslr_entry_t e);
      logic [3:0] n;
      n = s;
      if (e.run_low) begin
         n = s;
      end else if (!e.load_select_low) begin
         n = e.load_word;
      end else begin
         n = {s[2:0], e.serial_in};
      end
      return n;
   endfunction

   // Pin edge: high at this sample, low at the one before
   function automatic logic rising(input logic now, input logic prev);
      return now && !prev;
   endfunction

   // Saturating count so a long run of empty edges cannot wrap to zero
   function automatic logic [7:0] sat_inc(input logic [7:0] c);
      return (c == `FSLR_MISSED_MAX) ? c : c + 8'h01;
   endfunction

   // Read data of one register; write-only and unmapped words read zero
   function automatic logic [31:0] read_word(input logic [7:0] a,
                                             input logic       pin_en,
                                             input logic [3:0] s,
                                             input logic       inv,
                                             input logic       head_ok,
                                             input logic       full,
                                             input logic [3:0] lvl,
                                             input logic [7:0] missed);
      logic [31:0] w;
      w = 32'h0000_0000;
      if (is_reg(a, `FSLR_OFF_CTRL)) begin
         w[`FSLR_CTRL_PIN_BIT] = pin_en;
      end
      if (is_reg(a, `FSLR_OFF_STATUS)) begin
         w[`FSLR_ST_STG_MSB:`FSLR_ST_STG_LSB] = s;
         w[`FSLR_ST_INV_BIT]  = inv;
         w[`FSLR_ST_HEAD_BIT] = head_ok;
         w[`FSLR_ST_FULL_BIT] = full;
         w[`FSLR_ST_LVL_MSB:`FSLR_ST_LVL_LSB] = lvl;
      end
      if (is_reg(a, `FSLR_OFF_MISSED)) begin
         w[7:0] = missed;
      end
      return w;
   endfunction

   // ------------------------------------------------------------------
   // AHB-Lite slave
   // ------------------------------------------------------------------
   // NONSEQ or SEQ (htrans[1] set); IDLE and BUSY are not transfers
   assign accept = hsel && hready && htrans[1];

   always_comb begin
      bus_d         = bus_q;
      dp_addr_d     = dp_addr_q;
      hready_d      = hready_q;
      hrdata_d      = hrdata_q;
      pin_en_d      = pin_en_q;
      step_d        = 1'b0;
      missed_clr    = 1'b0;
      cmdq.in_valid = 1'b0;
      cmdq.in_data  = cmd_to_entry(hwdata);
      case (bus_q)
         FSLR_BUS_IDLE: begin
            if (accept && hwrite) begin
               // One wait state so hwdata is seen before completion
               bus_d     = FSLR_BUS_WDATA;
               dp_addr_d = haddr[7:0];
               hready_d  = 1'b0;
            end else if (accept) begin
               // Status is taken before this edge's own stage update;
               // a read never waits, so hready stays high
               hrdata_d = read_word(haddr[7:0], pin_en_q, stages_q, inv_q,
                                    cmdq.out_valid, !cmdq.in_ready,
                                    fifo_level, missed_q);
            end
         end
         FSLR_BUS_WDATA: begin
            // Data phase: hwdata stands only from here on
            if (is_reg(dp_addr_q, `FSLR_OFF_CMD)) begin
               // Full queue stretches the data phase: back-pressure.
               // No upper bound: it frees only at a register clock edge.
               cmdq.in_valid = 1'b1;
               if (cmdq.in_ready) begin
                  bus_d    = FSLR_BUS_IDLE;
                  hready_d = 1'b1;
               end
            end else begin
               bus_d    = FSLR_BUS_IDLE;
               hready_d = 1'b1;
               if (is_reg(dp_addr_q, `FSLR_OFF_STEP)) begin
                  // Acts at the next edge, through the same queue path
                  step_d = 1'b1;
               end
               if (is_reg(dp_addr_q, `FSLR_OFF_CTRL)) begin
                  pin_en_d = hwdata[`FSLR_CTRL_PIN_BIT];
               end
               if (is_reg(dp_addr_q, `FSLR_OFF_MISSED)) begin
                  missed_clr = 1'b1;
               end
            end
         end
         default: begin
            bus_d    = FSLR_BUS_IDLE;
            hready_d = 1'b1;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         bus_q     <= FSLR_BUS_IDLE;
         dp_addr_q <= 8'h00;
         hready_q  <= 1'b1;
         hrdata_q  <= 32'h0000_0000;
         hresp_q   <= 1'b0;
         pin_en_q  <= `FSLR_CTRL_RST;
         step_q    <= 1'b0;
      end else if (ce) begin
         bus_q     <= bus_d;
         dp_addr_q <= dp_addr_d;
         hready_q  <= hready_d;
         hrdata_q  <= hrdata_d;
         hresp_q   <= 1'b0;
         pin_en_q  <= pin_en_d;
         step_q    <= step_d;
      end
   end

   // ------------------------------------------------------------------
   // Register engine
   // ------------------------------------------------------------------
   always_comb begin
      head     = cmdq.out_data;
      clk_in_d = clk_input;
      // Edge from the pin or from a software step write
      reg_edge = (pin_en_q && rising(clk_input, clk_in_q)) || step_q;
      // Queue head is consumed only at an edge
      cmdq.out_ready = reg_edge;
      stages_d = stages_q;
      if (reg_edge && cmdq.out_valid) begin
         stages_d = stage_next(stages_q, head);
      end
      inv_d    = !stages_d[3];
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         clk_in_q <= 1'b0;
      end else if (ce) begin
         clk_in_q <= clk_in_d;
      end
   end

   // An edge with nothing queued holds; counted so software can tell.
   // A clear write and an edge in one cycle leave a count of one.
   always_comb begin
      missed_d = missed_clr ? `FSLR_MISSED_RST : missed_q;
      if (reg_edge && !cmdq.out_valid) begin
         missed_d = sat_inc(missed_d);
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         missed_q <= `FSLR_MISSED_RST;
      end else if (ce) begin
         missed_q <= missed_d;
      end
   end

   // Clear acts without the clock and ahead of ce; glitches on it clear too
   always_ff @(posedge mclk or posedge rst or negedge clear_low) begin
      if (rst || !clear_low) begin
         stages_q <= `FSLR_STAGES_RST;
         inv_q    <= `FSLR_INV_RST;
      end else if (ce) begin
         stages_q <= stages_d;
         inv_q    <= inv_d;
      end
   end

   // Command queue: eight memory words plus a registered head
   fslr_fifo #(
      .WIDTH (`FSLR_ENTRY_W),
      .DEPTH (`FSLR_FIFO_DEPTH)
   ) u_cmdq (
      .mclk  (mclk),
      .ce    (ce),
      .rst   (rst),
      .q     (cmdq),
      .level (fifo_level)
   );

   // Outputs straight from flops; every transfer answers OKAY
   assign reg_outputs        = stages_q;
   assign last_stage_inverse = inv_q;
   assign hreadyout          = hready_q;
   assign hresp              = hresp_q;
   assign hrdata             = hrdata_q;

endmodule

// File: tb/fslr_monitor.sv
// Port checker for the shift/load register block.
// Bound into fslr_top; sees its ports only, one clock domain.
`timescale 1ns/10ps
module fslr_monitor (
   // Clock, reset
   input wire logic        mclk,
   input wire logic        rst,
   // Register pins
   input wire logic        clk_input,
   input wire logic        clear_low,
   input wire logic [3:0]  reg_outputs,
   input wire logic        last_stage_inverse,
   // Bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata
);
   logic [3:0] step_q;
   logic [3:0] step_d;
   logic       acc;
   assign acc = hsel && hready && htrans[1];
   // STEP writes move the stages without any pin edge
   always_comb begin
      step_d = (step_q != 4'h0) ? step_q - 4'h1 : 4'h0;
      if (acc && hwrite && haddr[7:0] == 8'h04) begin
         step_d = 4'h8;
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         step_q <= 4'h0;
      end else begin
         step_q <= step_d;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   AST_INVERSE: assert property (
      last_stage_inverse == ~reg_outputs[3])
      else $error("inverse output differs from last stage");
   AST_CLEAR: assert property (
      !clear_low |-> reg_outputs == 4'h0 && last_stage_inverse)
      else $error("stages not cleared while clear is low");
   AST_EDGE_ONLY: assert property (
      (clear_low && $past(clear_low) && reg_outputs != $past(reg_outputs))
      |-> (($past(clk_input) && !$past(clk_input, 2)) || step_q != 4'h0))
      else $error("stages changed without a clock edge");
   AST_HIGH_LEVEL: assert property (
      ($past(clk_input) && $past(clk_input, 2) && clear_low
       && $past(clear_low) && step_q == 4'h0) |-> $stable(reg_outputs))
      else $error("stages changed while clock input stayed high");
   AST_STEADY: assert property (
      (!clk_input && !$past(clk_input) && clear_low && step_q == 4'h0)
      [*3] ##1 clear_low |-> $stable(reg_outputs))
      else $error("stages drifted while idle");
   AST_STATUS: assert property (
      (acc && !hwrite && haddr[7:0] == 8'h0C ##1 $stable(reg_outputs))
      |-> hrdata[4:0] == {last_stage_inverse, reg_outputs})
      else $error("status read does not mirror stages");
endmodule

bind fslr_top fslr_monitor u_mon (.mclk(mclk), .rst(rst),
   .clk_input(clk_input), .clear_low(clear_low),
   .reg_outputs(reg_outputs), .last_stage_inverse(last_stage_inverse),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hrdata(hrdata));

// File: tb/fslr_pins.sv
// Surrounding logic model: register clock pulses and asynchronous clear.
// A pulse stays high two mclk cycles, then low two, so one edge each.
`timescale 1ns/10ps
module fslr_pins (
   // Clock, reset
   input wire logic mclk,
   input wire logic rst,
   // Requests
   input wire logic fire,
   input wire logic clr_req,
   // Pins
   output logic     clk_input,
   output logic     clear_low
);
   logic [1:0] cnt;
   // Offset from mclk so the clear really arrives between edges
   assign #3 clear_low = ~clr_req;
   assign clk_input = cnt[1];
   always @(posedge mclk or posedge rst) begin
      if (rst) cnt <= 2'h0;
      else if (fire) cnt <= 2'h3;
      else if (cnt != 2'h0) cnt <= cnt - 2'h1;
   end
endmodule

// File: tb/tb_top.sv
// Self-checking bench: AHB-Lite master, pin model, read scoreboard.
// Assumes the design files and the bound port checker are compiled.
`timescale 1ns/10ps
module tb_top;
   logic        mclk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic        fire = 1'b0, clr = 1'b0, dph = 1'b0, sts = 1'b0;
   logic [31:0] ev;
   logic        hreadyout, hresp, clk_input, clear_low, inv;
   logic [1:0]  htrans = 2'h0;
   logic [3:0]  stg = 4'h0, q;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, lf = 32'h332E;
   logic [31:0] exp_q[$];
   logic [6:0]  fw[9];
   int          n_errors = 0, cmp_count = 0, cyc = 0;
   always #5 mclk = ~mclk;
   fslr_pins u_pins (.mclk(mclk), .rst(rst), .fire(fire), .clr_req(clr),
      .clk_input(clk_input), .clear_low(clear_low));
   fslr_top dut (.mclk(mclk), .ce(1'b1), .rst(rst), .clk_input(clk_input),
      .clear_low(clear_low), .reg_outputs(q), .last_stage_inverse(inv),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [3:0] nxt(input logic [3:0] c,
      input logic [6:0] e);
      if (e[0]) return c;
      return e[1] ? {c[2:0], e[2]} : e[6:3];
   endfunction
   function automatic logic [31:0] st(input logic [3:0] s);
      return {27'h0, ~s[3], s};
   endfunction
   task check(input string nm, input logic [31:0] seen, ex);
      cmp_count++;
      if (seen !== ex) begin
         n_errors++;
         $display("wrong value %s: expected %h seen %h", nm, ex, seen);
      end
   endtask
   task close_out;
      $display("errors %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Samples between edges, where the answer is settled
   task wait_rdy;
      @(negedge mclk);
      while (hreadyout !== 1'b1) begin
         @(negedge mclk);
      end
      @(posedge mclk);
   endtask
   task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      xfer(1'b0, a, 32'h0);
   endtask
   task cmd(input logic [6:0] e);
      xfer(1'b1, 8'h00, {24'h0, e[6:3], 1'b0, e[2:0]});
   endtask
   task pin_edge;
      fire <= 1'b1;
      @(posedge mclk);
      fire <= 1'b0;
      repeat (5) @(posedge mclk);
   endtask
   always @(negedge mclk) begin
      if (dph && hreadyout === 1'b1) begin
         ev = exp_q.pop_front();
         check("hrdata", hrdata, ev);
         check("hresp", {31'h0, hresp}, 32'h0);
         // Pins must agree with the status word while nothing moves
         if (sts) check("pins", {27'h0, inv, q}, ev & 32'h1F);
         dph = 1'b0;
      end
      if (hsel && htrans[1] && !hwrite && hreadyout === 1'b1) begin
         dph = 1'b1;
         sts = (haddr[7:0] == 8'h0C);
      end
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc > 30000) begin
         n_errors++;
         close_out;
      end
   end
   initial begin
      logic [6:0] e;
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rd(8'h0C, st(4'h0));
      rd(8'h08, 32'h1);
      rd(8'h10, 32'h0);
      rd(8'h20, 32'h0);
      rd(8'h00, 32'h0);
      pin_edge;
      rd(8'h10, 32'h1);
      xfer(1'b1, 8'h10, 32'h0);
      rd(8'h10, 32'h0);
      // First four passes walk every mode, the last pass loads, the rest are random
      for (int i = 0; i < 20; i++) begin
         lf = lfsr(lf);
         e = lf[6:0];
         if (i < 4) e[1:0] = {i[0], i[1]};
         if (i == 19) e = {e[2], stg[3:1], e[2], 2'b00};
         cmd(e);
         pin_edge;
         stg = nxt(stg, e);
         rd(8'h0C, st(stg));
      end
      // Fill to full with no edges, then drain one edge at a time
      for (int i = 0; i < 9; i++) begin
         lf = lfsr(lf);
         fw[i] = {lf[6:1], 1'b0};
         cmd(fw[i]);
      end
      rd(8'h0C, st(stg) | 32'h8300);
      for (int k = 1; k < 10; k++) begin
         pin_edge;
         stg = nxt(stg, fw[k-1]);
         rd(8'h0C, st(stg) | (k < 9 ? ((8 - k) << 12) | 32'h100 : 0));
      end
      cmd(7'h28);
      xfer(1'b1, 8'h04, 32'h0);
      repeat (4) @(posedge mclk);
      stg = 4'h5;
      rd(8'h0C, st(stg));
      xfer(1'b1, 8'h08, 32'h0);
      cmd(7'h60);
      pin_edge;
      rd(8'h0C, st(stg) | 32'h100);
      xfer(1'b1, 8'h08, 32'h1);
      pin_edge;
      stg = 4'hC;
      rd(8'h0C, st(stg));
      cmd(7'h48);
      clr <= 1'b1;
      repeat (3) @(posedge mclk);
      clr <= 1'b0;
      repeat (2) @(posedge mclk);
      rd(8'h0C, st(4'h0) | 32'h100);
      pin_edge;
      rd(8'h0C, st(4'h9));
      close_out;
   end
endmodule
